//--- core/irq_ident_pkg.sv
package irq_ident_pkg;

  // Register map, byte addresses
  localparam logic [7:0] ADDR_IDENT = 8'h08;
  localparam logic [7:0] ADDR_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_STATUS_VIEW = 8'h40;

  // Enable register bits
  localparam int EN_RX_AVAIL_BIT = 0;
  localparam int EN_TX_EMPTY_BIT = 1;
  localparam int EN_RX_ERR_BIT = 2;
  localparam int EN_MODEM_BIT = 3;
  localparam int EN_BUSY_BIT = 4;
  localparam logic [4:0] ENABLE_RESET = 5'h00;

  // Identification fields
  localparam int QUEUES_ON_MSB = 7;
  localparam int QUEUES_ON_LSB = 6;
  localparam logic [31:0] IDENT_RESET = 32'h0000_0001;

  typedef enum logic [3:0] {
    CODE_MODEM = 4'b0000,
    CODE_NONE = 4'b0001,
    CODE_TX_EMPTY = 4'b0010,
    CODE_RX_AVAIL = 4'b0100,
    CODE_RX_ERR = 4'b0110,
    CODE_BUSY = 4'b0111,
    CODE_TIMEOUT = 4'b1100
  } pending_code_t;

  // Character times of receive silence before a timeout
  localparam int TIMEOUT_CHARS = 4;

  // Event sources from the rest of the serial port
  typedef struct packed {
    logic rx_error;
    logic rx_char_ready;
    logic rx_at_trigger;
    logic rx_fifo_nonempty;
    logic rx_fifo_activity;
    logic char_time_tick;
    logic tx_hold_empty;
    logic tx_at_or_below_thr;
    logic thr_mode_on;
    logic queues_on_flag;
    logic auto_flow_on;
    logic peer_ready_change_flag;
    logic dsr_change;
    logic ring_change;
    logic carrier_change;
    logic port_busy;
  } event_src_t;

  // Software actions seen by the port
  typedef struct packed {
    logic err_status_read;
    logic rx_buffer_read;
    logic tx_hold_write;
    logic modem_status_read;
    logic port_status_read;
    logic line_ctrl_write;
  } sw_action_t;

endpackage : irq_ident_pkg

//--- core/uart_interrupt_identification.sv
// Function
// - Identification read-only, resets to idle code
// - Bits 7:6 show FIFOs on as 11
// - Code field shows highest pending event
// - Error, data/timeout, tx empty, modem, busy
// - Receiver errors raise code 0110
// - Error-status read clears receive error
// - Receive FIFO read clears receive error
// - Data code on char or trigger level
// - Buffer read or below trigger clears data
// - Four silent character times raise timeout
// - Receive buffer read clears timeout
// - Transmit empty or at/below threshold raises 0010
// - Ident read, write, above threshold clear
// - Modem line change raises code 0000
// - Auto flow masks peer-ready change
// - Modem-status read clears modem event
// - Line-control write while busy raises 0111
// - Port-status read clears busy event
// - Enables gate each source; data covers timeout
// - FIFO-on indication follows FIFO enable
`timescale 1ns/10ps
`default_nettype none
module uart_interrupt_identification
  import irq_ident_pkg::*;
#(
  parameter bit legacy_compat_param = 1'b0,
  parameter int TIMEOUT_CHARS_P = TIMEOUT_CHARS
)
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [31:0] rdata_out,
  input wire event_src_t src_in,
  input wire sw_action_t act_in,
  output logic [3:0] pending_code_out,
  output logic irq_pending_out
);

  // Refuse settings that the silence counter cannot hold
  if (TIMEOUT_CHARS_P < 1 || TIMEOUT_CHARS_P > 15)
  begin : g_bad_timeout
    $error("TIMEOUT_CHARS_P must be 1 to 15");
  end

  // Address match, shared by the ident read and the enable write
  function automatic logic addr_hit(input logic strobe,
                                    input logic [7:0] addr,
                                    input logic [7:0] target);
    addr_hit = strobe && (addr == target);
  endfunction : addr_hit

  // Enables, latched event flags (one per source), silence count and tx edge history
  logic [4:0] enable_q;
  logic err_q;
  logic timeout_q;
  logic tx_empty_q;
  logic modem_q;
  logic busy_q;
  logic rx_avail_q;
  logic [3:0] silent_q;
  logic tx_empty_prev_q;
  // Decoded strobes and combinational helpers
  pending_code_t code;
  logic ident_read;
  logic enable_write;
  logic tx_empty_src;
  logic modem_change;
  logic rx_avail_raw;
  logic quiet_restart;
  logic timeout_hit;
  logic busy_attempt;
  logic [31:0] read_word;

  assign ident_read = addr_hit(read_in, addr_in, ADDR_IDENT);
  assign enable_write = addr_hit(write_in, addr_in, ADDR_ENABLE);

  // Only the enable offset takes writes; ident stays read-only
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      enable_q <= ENABLE_RESET;
    end
    else if (enable_write)
    begin
      enable_q <= wdata_in[4:0];
    end
  end

  // Receive error; new error wins over a clear in the same cycle
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      err_q <= 1'b0;
    end
    else if (src_in.rx_error)
    begin
      err_q <= 1'b1;
    end
    else if (act_in.err_status_read || act_in.rx_buffer_read)
    begin
      err_q <= 1'b0;
    end
  end

  // Level source: char waiting, or trigger reached in FIFO mode
  always_comb
  begin
    if (src_in.queues_on_flag)
    begin
      rx_avail_raw = src_in.rx_at_trigger;
    end
    else
    begin
      rx_avail_raw = src_in.rx_char_ready;
    end
  end

  // Non-FIFO: held until buffer read, a waiting char wins the race
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rx_avail_q <= 1'b0;
    end
    else if (src_in.queues_on_flag)
    begin
      rx_avail_q <= src_in.rx_at_trigger;
    end
    else if (src_in.rx_char_ready)
    begin
      rx_avail_q <= 1'b1;
    end
    else if (act_in.rx_buffer_read)
    begin
      rx_avail_q <= 1'b0;
    end
  end

  // A buffer read is traffic too, so it restarts the quiet count
  assign quiet_restart = !src_in.queues_on_flag || !src_in.rx_fifo_nonempty
                         || src_in.rx_fifo_activity
                         || act_in.rx_buffer_read;

  // Saturates so a long silence cannot wrap into a second timeout
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      silent_q <= 4'h0;
    end
    else if (quiet_restart)
    begin
      silent_q <= 4'h0;
    end
    else if (src_in.char_time_tick && silent_q != 4'hf)
    begin
      silent_q <= silent_q + 4'h1;
    end
  end

  assign timeout_hit = src_in.char_time_tick && !quiet_restart
                       && silent_q == 4'(TIMEOUT_CHARS_P - 1);

  // Clear wins: the buffer read takes the char that timed out
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      timeout_q <= 1'b0;
    end
    else if (act_in.rx_buffer_read || !src_in.queues_on_flag)
    begin
      timeout_q <= 1'b0;
    end
    else if (timeout_hit)
    begin
      timeout_q <= 1'b1;
    end
  end

  // Threshold compare only means something with the FIFOs on
  assign tx_empty_src = (src_in.thr_mode_on && src_in.queues_on_flag)
                        ? src_in.tx_at_or_below_thr
                        : src_in.tx_hold_empty;

  // Raised on the rising edge of the source, so an ident read can clear it
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      tx_empty_prev_q <= 1'b0;
    end
    else
    begin
      tx_empty_prev_q <= tx_empty_src;
    end
  end

  // Source falling, a holding write or a reported ident read clear it
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      tx_empty_q <= 1'b0;
    end
    else if (tx_empty_src && !tx_empty_prev_q)
    begin
      tx_empty_q <= 1'b1;
    end
    else if (!tx_empty_src || act_in.tx_hold_write)
    begin
      tx_empty_q <= 1'b0;
    end
    else if (ident_read && code == CODE_TX_EMPTY)
    begin
      tx_empty_q <= 1'b0;
    end
  end

  assign modem_change = (src_in.peer_ready_change_flag
                         && !src_in.auto_flow_on)
                        || src_in.dsr_change || src_in.ring_change
                        || src_in.carrier_change;

  // Set wins: a line change in the read cycle is kept
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      modem_q <= 1'b0;
    end
    else if (modem_change)
    begin
      modem_q <= 1'b1;
    end
    else if (act_in.modem_status_read)
    begin
      modem_q <= 1'b0;
    end
  end

  // Busy detect only exists without legacy compatibility
  assign busy_attempt = !legacy_compat_param && act_in.line_ctrl_write
                        && src_in.port_busy;

  // Set wins, so a retried write in the read cycle is not lost
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      busy_q <= 1'b0;
    end
    else if (busy_attempt)
    begin
      busy_q <= 1'b1;
    end
    else if (act_in.port_status_read)
    begin
      busy_q <= 1'b0;
    end
  end

  // Priority encoder over enabled sources
  always_comb
  begin
    if (err_q && enable_q[EN_RX_ERR_BIT])
    begin
      code = CODE_RX_ERR;
    end
    // Data beats timeout at the same level
    else if (enable_q[EN_RX_AVAIL_BIT] && (rx_avail_q || rx_avail_raw))
    begin
      code = CODE_RX_AVAIL;
    end
    else if (enable_q[EN_RX_AVAIL_BIT] && timeout_q)
    begin
      code = CODE_TIMEOUT;
    end
    else if (enable_q[EN_TX_EMPTY_BIT] && tx_empty_q)
    begin
      code = CODE_TX_EMPTY;
    end
    else if (enable_q[EN_MODEM_BIT] && modem_q)
    begin
      code = CODE_MODEM;
    end
    else if (enable_q[EN_BUSY_BIT] && busy_q)
    begin
      code = CODE_BUSY;
    end
    else
    begin
      code = CODE_NONE;
    end
  end

  assign pending_code_out = code;
  // Level for the port's interrupt line
  assign irq_pending_out = (code != CODE_NONE);

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    read_word = 32'h0000_0000;
    if (addr_in == ADDR_IDENT)
    begin
      read_word[QUEUES_ON_MSB:QUEUES_ON_LSB] =
        {2{src_in.queues_on_flag}};
      read_word[3:0] = code;
    end
    else if (addr_in == ADDR_ENABLE)
    begin
      read_word[4:0] = enable_q;
    end
    else if (addr_in == ADDR_STATUS_VIEW)
    begin
      read_word[5:0] = {busy_q, modem_q, tx_empty_q, timeout_q,
                        rx_avail_q, err_q};
    end
  end

  // Registered read data; it stands until the next read strobe
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rdata_out <= 32'h0000_0000;
    end
    else if (read_in)
    begin
      rdata_out <= read_word;
    end
  end

endmodule : uart_interrupt_identification
`default_nettype wire

//--- verification/serial_peer_model.sv
`timescale 1ns/10ps
`default_nettype none
module serial_peer_model
(
  input wire logic clk_in,
  output logic [3:0] line_chg_out
);
  // Bit 0 peer ready, 1 data set, 2 ring, 3 carrier
  initial line_chg_out = 4'h0;
  task automatic flip(input int i);
    @(posedge clk_in);
    line_chg_out[i] <= 1'b1;
    @(posedge clk_in);
    line_chg_out[i] <= 1'b0;
  endtask : flip
endmodule : serial_peer_model
`default_nettype wire

//--- verification/test_uart_interrupt_identification.sv
`timescale 1ns/10ps
`default_nettype none
module test_uart_interrupt_identification
  import irq_ident_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic wr_s = 1'b0, rd_s = 1'b0, irq_o;
  event_src_t s = '0, srcw;
  sw_action_t a = '0;
  logic [3:0] chg, code_o;
  int fail_count = 0, checks = 0;
  always #2 clk = ~clk;
  always_comb
  begin
    srcw = s;
    {srcw.carrier_change, srcw.ring_change, srcw.dsr_change,
      srcw.peer_ready_change_flag} = chg;
  end
  uart_interrupt_identification u_uart_interrupt_identification (
    .ref_clk_in(clk), .reset_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
    .write_in(wr_s), .read_in(rd_s), .rdata_out(rdata), .src_in(srcw),
    .act_in(a), .pending_code_out(code_o), .irq_pending_out(irq_o));
  serial_peer_model u_serial_peer_model (.clk_in(clk), .line_chg_out(chg));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic code(input logic [3:0] e);
    repeat (2) @(negedge clk);
    chk({28'h0, code_o}, {28'h0, e});
    chk({31'h0, irq_o}, {31'h0, e != CODE_NONE});
  endtask : code
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk);
    addr <= ad;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd
  task automatic act(input sw_action_t x);
    @(posedge clk);
    a <= x;
    @(posedge clk);
    a <= '0;
  endtask : act
  task automatic ev(input event_src_t x);
    @(posedge clk);
    s <= s | x;
    @(posedge clk);
    s <= s & ~x;
  endtask : ev
  task automatic t_regs;
    rd(ADDR_IDENT, v);
    chk(v, IDENT_RESET);
    wr(ADDR_IDENT, 32'hffff_ffff);
    rd(ADDR_IDENT, v);
    chk(v, IDENT_RESET);
    rd(8'h10, v);
    chk(v, 32'h0);
    wr(ADDR_ENABLE, 32'h1f);
    rd(ADDR_ENABLE, v);
    chk(v, 32'h1f);
  endtask : t_regs
  task automatic t_rxerr;
    ev(16'h8000);
    code(CODE_RX_ERR);
    act(6'h20);
    code(CODE_NONE);
    ev(16'h8000);
    act(6'h10);
    code(CODE_NONE);
  endtask : t_rxerr
  task automatic t_data;
    @(posedge clk);
    s.rx_char_ready <= 1'b1;
    code(CODE_RX_AVAIL);
    @(posedge clk);
    s.rx_char_ready <= 1'b0;
    act(6'h10);
    code(CODE_NONE);
    @(posedge clk);
    s.queues_on_flag <= 1'b1;
    s.rx_at_trigger <= 1'b1;
    code(CODE_RX_AVAIL);
    rd(ADDR_IDENT, v);
    chk(v, 32'hc4);
    @(posedge clk);
    s.rx_at_trigger <= 1'b0;
    code(CODE_NONE);
  endtask : t_data
  task automatic t_tmo;
    @(posedge clk);
    s.rx_fifo_nonempty <= 1'b1;
    repeat (3) ev(16'h0400);
    code(CODE_NONE);
    ev(16'h0400);
    code(CODE_TIMEOUT);
    @(posedge clk);
    s.rx_at_trigger <= 1'b1;
    code(CODE_RX_AVAIL);
    @(posedge clk);
    s.rx_at_trigger <= 1'b0;
    s.rx_fifo_nonempty <= 1'b0;
    act(6'h10);
    code(CODE_NONE);
  endtask : t_tmo
  task automatic t_tx;
    @(posedge clk);
    s.queues_on_flag <= 1'b0;
    s.tx_hold_empty <= 1'b1;
    code(CODE_TX_EMPTY);
    rd(ADDR_IDENT, v);
    chk(v, 32'h02);
    code(CODE_NONE);
    @(posedge clk);
    s.tx_hold_empty <= 1'b0;
    @(posedge clk);
    s.tx_hold_empty <= 1'b1;
    ev(16'h8000);
    code(CODE_RX_ERR);
    act(6'h20);
    code(CODE_TX_EMPTY);
    act(6'h08);
    code(CODE_NONE);
    @(posedge clk);
    s.tx_hold_empty <= 1'b0;
    s.thr_mode_on <= 1'b1;
    s.queues_on_flag <= 1'b1;
    @(posedge clk);
    s.tx_at_or_below_thr <= 1'b1;
    code(CODE_TX_EMPTY);
    @(posedge clk);
    s.tx_at_or_below_thr <= 1'b0;
    code(CODE_NONE);
  endtask : t_tx
  task automatic t_modem;
    for (int i = 0; i < 4; i++)
    begin
      u_serial_peer_model.flip(i);
      code(CODE_MODEM);
      act(6'h04);
      code(CODE_NONE);
    end
    @(posedge clk);
    s.auto_flow_on <= 1'b1;
    u_serial_peer_model.flip(0);
    code(CODE_NONE);
    u_serial_peer_model.flip(1);
    code(CODE_MODEM);
    act(6'h04);
  endtask : t_modem
  task automatic t_busy;
    act(6'h01);
    code(CODE_NONE);
    @(posedge clk);
    s.port_busy <= 1'b1;
    act(6'h01);
    code(CODE_BUSY);
    rd(ADDR_STATUS_VIEW, v);
    chk(v, 32'h20);
    act(6'h02);
    code(CODE_NONE);
    wr(ADDR_ENABLE, 32'h0);
    ev(16'h8000);
    code(CODE_NONE);
  endtask : t_busy
  task automatic t_rst;
    wr(ADDR_ENABLE, 32'h1f);
    code(CODE_RX_ERR);
    @(posedge clk);
    rst_n <= 1'b0;
    s.queues_on_flag <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_IDENT, v);
    chk(v, IDENT_RESET);
    code(CODE_NONE);
  endtask : t_rst
  task automatic close_out;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_rxerr;
    t_data;
    t_tmo;
    t_tx;
    t_modem;
    t_busy;
    t_rst;
    close_out;
  end
  // Cuts a hang short
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    close_out;
  end
endmodule : test_uart_interrupt_identification
`default_nettype wire

//--- verification/uart_irq_props.sv
`timescale 1ns/10ps
`default_nettype none
module uart_irq_props
  import irq_ident_pkg::*;
#(
  parameter bit legacy_compat_param = 1'b0,
  parameter int TIMEOUT_CHARS_P = TIMEOUT_CHARS
)
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic [31:0] rdata_out,
  input wire event_src_t src_in,
  input wire sw_action_t act_in,
  input wire logic [3:0] pending_code_out,
  input wire logic irq_pending_out
);
  logic [4:0] en_q;
  logic ok;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Shadow of the enables, the checker cannot see inside
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
    if (!reset_n_in) en_q <= ENABLE_RESET;
    else if (write_in && addr_in == ADDR_ENABLE) en_q <= wdata_in[4:0];
  assign ok = !write_in;
  idle_flag_a:
    assert property (irq_pending_out == (pending_code_out != CODE_NONE))
    else $error("flag and code disagree");
  ident_read_a:
    assert property (read_in && addr_in == ADDR_IDENT |=> rdata_out ==
      {24'h0, {2{$past(src_in.queues_on_flag)}}, 2'b00,
      $past(pending_code_out)})
    else $error("bad ident read");
  err_code_a:
    assert property (en_q[EN_RX_ERR_BIT] && ok && src_in.rx_error |=>
      pending_code_out == CODE_RX_ERR)
    else $error("rx error not shown");
  err_clear_a:
    assert property (pending_code_out == CODE_RX_ERR &&
      act_in.err_status_read && !src_in.rx_error |=>
      pending_code_out != CODE_RX_ERR)
    else $error("rx error not cleared");
  avail_rank_a:
    assert property ((en_q[EN_RX_AVAIL_BIT] && ok && src_in.queues_on_flag
      && src_in.rx_at_trigger)[*2] |->
      pending_code_out inside {CODE_RX_ERR, CODE_RX_AVAIL})
    else $error("rx data not shown");
  modem_code_a:
    assert property (pending_code_out == CODE_NONE && en_q[EN_MODEM_BIT]
      && ok && src_in.dsr_change |=> irq_pending_out)
    else $error("modem change lost");
  busy_code_a:
    assert property (!legacy_compat_param && en_q[EN_BUSY_BIT] && ok &&
      act_in.line_ctrl_write && src_in.port_busy |=> irq_pending_out)
    else $error("busy not shown");
  busy_clear_a:
    assert property (pending_code_out == CODE_BUSY &&
      act_in.port_status_read && !act_in.line_ctrl_write |=>
      pending_code_out != CODE_BUSY)
    else $error("busy not cleared");
  tx_clear_a:
    assert property (read_in && addr_in == ADDR_IDENT && $stable(src_in)
      && pending_code_out == CODE_TX_EMPTY |=>
      pending_code_out != CODE_TX_EMPTY)
    else $error("tx empty not cleared");
  cover property (pending_code_out == CODE_TIMEOUT);
  cover property (pending_code_out == CODE_MODEM);
  cover property (pending_code_out == CODE_BUSY);
endmodule : uart_irq_props
bind uart_interrupt_identification uart_irq_props #(
  .legacy_compat_param(legacy_compat_param),
  .TIMEOUT_CHARS_P(TIMEOUT_CHARS_P)
) u_uart_irq_props (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in),
  .read_in(read_in), .rdata_out(rdata_out), .src_in(src_in),
  .act_in(act_in), .pending_code_out(pending_code_out),
  .irq_pending_out(irq_pending_out));
`default_nettype wire
